// >>> design/io_port_pkg.sv
// constants for the general-purpose i/o port set
package io_port_pkg;
  // bus widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // port widths
  localparam int LED_W  = 8;
  localparam int ANA_W  = 8;
  localparam int OSC_W  = 2;
  localparam int AUX_W  = 2;
  localparam int PIN_W  = LED_W + ANA_W + OSC_W + AUX_W;
  // register offsets
  localparam logic [3:0] LED_DATA_OFS = 4'h0;
  localparam logic [3:0] LED_DIR_OFS  = 4'h1;
  localparam logic [3:0] ANA_DATA_OFS = 4'h2;
  localparam logic [3:0] ANA_DIR_OFS  = 4'h3;
  localparam logic [3:0] OSC_DATA_OFS = 4'h4;
  localparam logic [3:0] OSC_DIR_OFS  = 4'h5;
  localparam logic [3:0] AUX_DATA_OFS = 4'h6;
  localparam logic [3:0] AUX_DIR_OFS  = 4'h7;
  localparam logic [3:0] LED_PU_OFS   = 4'h8;
  localparam logic [3:0] ANA_PU_OFS   = 4'h9;
  localparam logic [3:0] MISC_PU_OFS  = 4'hA;
  localparam logic [3:0] LED_HD_OFS   = 4'hB;
  // field positions inside the shared pull-up register
  localparam int MISC_OSC_LSB = 0;
  localparam int MISC_AUX_LSB = 2;
  // bit of the oscillator port that is output only
  localparam int OSC_OUT_ONLY_BIT = 0;
  // values after reset
  localparam logic [7:0] DATA_RST    = 8'h00;
  localparam logic [7:0] DIR_RST     = 8'h00;
  localparam logic [1:0] OSC_DIR_RST = 2'h1;
  localparam logic [7:0] PU_RST      = 8'h00;
  localparam logic [7:0] HD_RST      = 8'h00;
  // synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;
endpackage : io_port_pkg

// >>> design/pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import io_port_pkg::*;
#(
  parameter int WIDTH = 1
)(
  // clock, reset, enable
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // pin levels in and synchronised levels out
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;   // first stage, read only by the second
  logic [WIDTH-1:0] meta_nxt; // next first stage
  logic [WIDTH-1:0] sync_r;   // second stage
  logic [WIDTH-1:0] sync_nxt; // next second stage

  // shift when enabled, hold otherwise
  always_comb
  begin
    meta_nxt = ce ? async_in : meta_r;
    sync_nxt = ce ? meta_r : sync_r;
  end

  // stage registers clear to zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule : pin_sync
`default_nettype wire

// >>> design/mcu_io_port_set.sv
// general-purpose i/o port set with register port
// Summary of operation
// - analog/key port: eight pins, per-pin direction
// - oscillator port: bit0 output only, bit1 directed
// - auxiliary port: two pins, per-pin direction
// - outputs three-state, released when pin is input
// - software pull-up enable per pin
// - led port normal or high drive select
// - strap picks oscillator or port use
// - low reset holds port initial state
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mcu_io_port_set
  import io_port_pkg::*;
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output var  logic [DATA_W-1:0] rdata,
  // led port pins
  input  wire logic [LED_W-1:0]  led_port_in,
  output var  logic [LED_W-1:0]  led_port_out,
  output var  logic [LED_W-1:0]  led_port_oe,
  output var  logic [LED_W-1:0]  led_port_pu,
  output var  logic [LED_W-1:0]  led_port_hd,
  // analog/key port pins
  input  wire logic [ANA_W-1:0]  analog_key_port_in,
  output var  logic [ANA_W-1:0]  analog_key_port_out,
  output var  logic [ANA_W-1:0]  analog_key_port_oe,
  output var  logic [ANA_W-1:0]  analog_key_port_pu,
  // oscillator-shared port pins
  input  wire logic [OSC_W-1:0]  oscillator_shared_port_in,
  output var  logic [OSC_W-1:0]  oscillator_shared_port_out,
  output var  logic [OSC_W-1:0]  oscillator_shared_port_oe,
  output var  logic [OSC_W-1:0]  oscillator_shared_port_pu,
  // auxiliary port pins
  input  wire logic [AUX_W-1:0]  auxiliary_port_in,
  output var  logic [AUX_W-1:0]  auxiliary_port_out,
  output var  logic [AUX_W-1:0]  auxiliary_port_oe,
  output var  logic [AUX_W-1:0]  auxiliary_port_pu,
  // function-setting strap and its effect
  input  wire logic              osc_strap,
  output var  logic              osc_mode
);
  // software-visible state
  logic [LED_W-1:0] led_dat_r, led_dat_nxt;   // led output latch
  logic [LED_W-1:0] led_dir_r, led_dir_nxt;   // led direction, 1 = output
  logic [ANA_W-1:0] ana_dat_r, ana_dat_nxt;   // analog/key output latch
  logic [ANA_W-1:0] ana_dir_r, ana_dir_nxt;   // analog/key direction
  logic [OSC_W-1:0] osc_dat_r, osc_dat_nxt;   // oscillator port latch
  logic [OSC_W-1:0] osc_dir_r, osc_dir_nxt;   // oscillator port direction
  logic [AUX_W-1:0] aux_dat_r, aux_dat_nxt;   // auxiliary latch
  logic [AUX_W-1:0] aux_dir_r, aux_dir_nxt;   // auxiliary direction
  logic [LED_W-1:0] led_pu_r, led_pu_nxt;     // led pull-ups
  logic [ANA_W-1:0] ana_pu_r, ana_pu_nxt;     // analog/key pull-ups
  logic [7:0]       misc_pu_r, misc_pu_nxt;   // osc and aux pull-ups
  logic [LED_W-1:0] led_hd_r, led_hd_nxt;     // led high drive
  logic [DATA_W-1:0] rdata_r, rdata_nxt;      // read data, one cycle late
  // strap capture
  logic             strap_done_r, strap_done_nxt; // strap taken
  logic             osc_mode_r, osc_mode_nxt;     // oscillator use
  logic [1:0]       strap_cnt_r, strap_cnt_nxt;   // enabled edges since reset, held once the strap is taken
  // synchronised pins, strap in the top bit
  logic [PIN_W:0]   pin_s;
  logic [LED_W-1:0] led_s;
  logic [ANA_W-1:0] ana_s;
  logic [OSC_W-1:0] osc_s;
  logic [AUX_W-1:0] aux_s;
  logic             strap_s;
  // read-back views
  logic [LED_W-1:0] led_view;
  logic [ANA_W-1:0] ana_view;
  logic [OSC_W-1:0] osc_view;
  logic [AUX_W-1:0] aux_view;
  logic [OSC_W-1:0] osc_dir_eff;  // direction with output-only bit forced

  // every pin and the strap pass two flops before use
  pin_sync #(.WIDTH(PIN_W + 1)) u_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .async_in ({osc_strap, auxiliary_port_in, oscillator_shared_port_in,
                analog_key_port_in, led_port_in}),
    .sync_out (pin_s)
  );

  assign led_s   = pin_s[LED_W-1:0];
  assign ana_s   = pin_s[LED_W+ANA_W-1:LED_W];
  assign osc_s   = pin_s[LED_W+ANA_W+OSC_W-1:LED_W+ANA_W];
  assign aux_s   = pin_s[PIN_W-1:LED_W+ANA_W+OSC_W];
  assign strap_s = pin_s[PIN_W];

  // output-only bit always reads as output and drives in port use
  always_comb
  begin
    osc_dir_eff = osc_dir_r;
    osc_dir_eff[OSC_OUT_ONLY_BIT] = 1'b1;
  end

  // per-pin view: latch when output, synced level when input
  always_comb
  begin
    led_view = (led_dir_r & led_dat_r) | (~led_dir_r & led_s);
    ana_view = (ana_dir_r & ana_dat_r) | (~ana_dir_r & ana_s);
    osc_view = (osc_dir_eff & osc_dat_r) | (~osc_dir_eff & osc_s);
    aux_view = (aux_dir_r & aux_dat_r) | (~aux_dir_r & aux_s);
  end

  // register writes and read capture
  always_comb
  begin
    led_dat_nxt = led_dat_r;
    led_dir_nxt = led_dir_r;
    ana_dat_nxt = ana_dat_r;
    ana_dir_nxt = ana_dir_r;
    osc_dat_nxt = osc_dat_r;
    osc_dir_nxt = osc_dir_r;
    aux_dat_nxt = aux_dat_r;
    aux_dir_nxt = aux_dir_r;
    led_pu_nxt  = led_pu_r;
    ana_pu_nxt  = ana_pu_r;
    misc_pu_nxt = misc_pu_r;
    led_hd_nxt  = led_hd_r;
    rdata_nxt   = '0; // read data stands only in the cycle after the strobe
    if (wr_stb)
    begin
      unique case (addr)
        LED_DATA_OFS: led_dat_nxt = wdata;
        LED_DIR_OFS:  led_dir_nxt = wdata;
        ANA_DATA_OFS: ana_dat_nxt = wdata;
        ANA_DIR_OFS:  ana_dir_nxt = wdata;
        OSC_DATA_OFS: osc_dat_nxt = wdata[OSC_W-1:0];
        OSC_DIR_OFS:  osc_dir_nxt = wdata[OSC_W-1:0] | OSC_DIR_RST;
        AUX_DATA_OFS: aux_dat_nxt = wdata[AUX_W-1:0];
        AUX_DIR_OFS:  aux_dir_nxt = wdata[AUX_W-1:0];
        LED_PU_OFS:   led_pu_nxt  = wdata;
        ANA_PU_OFS:   ana_pu_nxt  = wdata;
        MISC_PU_OFS:  misc_pu_nxt = {4'h0, wdata[3:0]};
        LED_HD_OFS:   led_hd_nxt  = wdata;
        default:      ; // unmapped writes are dropped
      endcase
    end
    if (rd_stb)
    begin
      unique case (addr)
        LED_DATA_OFS: rdata_nxt = led_view;
        LED_DIR_OFS:  rdata_nxt = led_dir_r;
        ANA_DATA_OFS: rdata_nxt = ana_view;
        ANA_DIR_OFS:  rdata_nxt = ana_dir_r;
        OSC_DATA_OFS: rdata_nxt = {6'h00, osc_view};
        OSC_DIR_OFS:  rdata_nxt = {6'h00, osc_dir_eff};
        AUX_DATA_OFS: rdata_nxt = {6'h00, aux_view};
        AUX_DIR_OFS:  rdata_nxt = {6'h00, aux_dir_r};
        LED_PU_OFS:   rdata_nxt = led_pu_r;
        ANA_PU_OFS:   rdata_nxt = ana_pu_r;
        MISC_PU_OFS:  rdata_nxt = misc_pu_r;
        LED_HD_OFS:   rdata_nxt = led_hd_r;
        default:      rdata_nxt = 8'h00; // unmapped reads answer zero
      endcase
    end
  end

  // strap is non-volatile, so it is taken once after reset and then held;
  // the capture waits until the synchroniser holds the real strap level,
  // since its stages leave reset at zero and would hide a set strap
  always_comb
  begin
    strap_cnt_nxt  = strap_done_r ? strap_cnt_r : strap_cnt_r + 2'h1;
    strap_done_nxt = strap_done_r | (strap_cnt_r == 2'(SYNC_STAGES));
    osc_mode_nxt   = strap_done_r ? osc_mode_r : strap_s;
  end

  // state registers; ce low freezes everything
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      led_dat_r    <= DATA_RST;
      led_dir_r    <= DIR_RST;
      ana_dat_r    <= DATA_RST;
      ana_dir_r    <= DIR_RST;
      osc_dat_r    <= DATA_RST[OSC_W-1:0];
      osc_dir_r    <= OSC_DIR_RST;
      aux_dat_r    <= DATA_RST[AUX_W-1:0];
      aux_dir_r    <= DIR_RST[AUX_W-1:0];
      led_pu_r     <= PU_RST;
      ana_pu_r     <= PU_RST;
      misc_pu_r    <= PU_RST;
      led_hd_r     <= HD_RST;
      rdata_r      <= '0;
      strap_done_r <= 1'b0;
      osc_mode_r   <= 1'b0;
      strap_cnt_r  <= 2'h0;
    end
    else if (ce)
    begin
      led_dat_r    <= led_dat_nxt;
      led_dir_r    <= led_dir_nxt;
      ana_dat_r    <= ana_dat_nxt;
      ana_dir_r    <= ana_dir_nxt;
      osc_dat_r    <= osc_dat_nxt;
      osc_dir_r    <= osc_dir_nxt;
      aux_dat_r    <= aux_dat_nxt;
      aux_dir_r    <= aux_dir_nxt;
      led_pu_r     <= led_pu_nxt;
      ana_pu_r     <= ana_pu_nxt;
      misc_pu_r    <= misc_pu_nxt;
      led_hd_r     <= led_hd_nxt;
      rdata_r      <= rdata_nxt;
      strap_done_r <= strap_done_nxt;
      osc_mode_r   <= osc_mode_nxt;
      strap_cnt_r  <= strap_cnt_nxt;
    end
  end

  // pin drivers: enable only where direction says output
  always_comb
  begin
    led_port_out = led_dat_r;
    led_port_oe  = led_dir_r;
    led_port_pu  = led_pu_r & ~led_dir_r; // pull-up only matters on inputs
    led_port_hd  = led_hd_r & led_dir_r;
    analog_key_port_out = ana_dat_r;
    analog_key_port_oe  = ana_dir_r;
    analog_key_port_pu  = ana_pu_r & ~ana_dir_r;
    // oscillator use hands both pins to the clock circuit
    oscillator_shared_port_out = osc_mode_r ? 2'h0 : osc_dat_r;
    oscillator_shared_port_oe  = osc_mode_r ? 2'h0 : osc_dir_eff;
    oscillator_shared_port_pu  = osc_mode_r ? 2'h0 :
                                 misc_pu_r[MISC_OSC_LSB +: OSC_W] & ~osc_dir_eff;
    auxiliary_port_out = aux_dat_r;
    auxiliary_port_oe  = aux_dir_r;
    auxiliary_port_pu  = misc_pu_r[MISC_AUX_LSB +: AUX_W] & ~aux_dir_r;
    osc_mode = osc_mode_r;
    rdata    = rdata_r;
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  logic past_valid_r; // first sampled edge after release
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      past_valid_r <= 1'b0;
    else
      past_valid_r <= 1'b1;
  end

  sequence s_ana_view_read;
    ce && rd_stb && addr == ANA_DATA_OFS;
  endsequence

  a_ana_dir_oe: assert property (analog_key_port_oe == ana_dir_r)
    else $error("analog key enable differs from direction");
  a_osc_out_only: assert property (!osc_mode |-> oscillator_shared_port_oe[0])
    else $error("oscillator output-only pin not driving");
  a_aux_dir_write: assert property (ce && wr_stb && addr == AUX_DIR_OFS
      |=> auxiliary_port_oe == $past(wdata[AUX_W-1:0]))
    else $error("auxiliary direction write not applied");
  a_led_tristate: assert property ((led_port_oe & ~led_dir_r) == 8'h00)
    else $error("led pin driven while input");
  // pull-up stands only on pins set as input
  a_pu_write: assert property (ce && wr_stb && addr == LED_PU_OFS
      |=> led_port_pu == ($past(wdata) & ~led_dir_r))
    else $error("led pull-up write not applied");
  // high drive is only offered on pins that the port drives
  a_hd_write: assert property (ce && wr_stb && addr == LED_HD_OFS
      |=> led_port_hd == ($past(wdata) & led_dir_r))
    else $error("led high drive write not applied");
  a_osc_release: assert property (osc_mode |-> oscillator_shared_port_oe == 2'h0
      && oscillator_shared_port_pu == 2'h0)
    else $error("oscillator pins driven in clock use");
  // read data stands for one cycle and then returns to zero
  a_ana_read_view: assert property (s_ana_view_read |=> rdata == $past(ana_view)
      ##1 (!$past(ce) || $past(rd_stb) || rdata == 8'h00))
    else $error("analog key read data wrong");
  // first sampled edge after any release still sees the reset state
  a_reset_state: assert property (!past_valid_r |-> led_port_oe == 8'h00
      && analog_key_port_oe == 8'h00 && rdata == 8'h00)
    else $error("port not in initial state after reset");
  // strap settles through the synchroniser, then oscillator use is frozen
  sequence s_strap_taken;
    ce && strap_done_r;
  endsequence
  a_strap_hold: assert property (s_strap_taken |=> $stable(osc_mode))
    else $error("oscillator mode changed after strap capture");
  // a pull-up never fights a pin that the port drives
  a_pu_not_driven: assert property ((led_port_pu & led_port_oe) == 8'h00
      && (analog_key_port_pu & analog_key_port_oe) == 8'h00)
    else $error("pull-up on a driven pin");
endmodule : mcu_io_port_set
`default_nettype wire

// >>> tb/pin_board.sv
// board model: level seen on each pin of one port
`timescale 1ns/1ps
`default_nettype none
module pin_board #(
  parameter int W = 8
)(
  // design side of the pins
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  // board side drivers
  input  wire logic [W-1:0] ext,
  input  wire logic [W-1:0] ext_en,
  input  wire logic         flt,
  output var  logic [W-1:0] pin
);
  // driver wins; a released, unpulled pin wanders so stale values never pass
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (oe[i]) pin[i] = out[i];
      else if (ext_en[i]) pin[i] = ext[i];
      else if (pu[i]) pin[i] = 1'b1;
      else pin[i] = flt ^ i[0];
    end
  end
endmodule : pin_board
`default_nettype wire

// >>> tb/tb_mcu_io_port_set.sv
// self-checking bench for the i/o port set
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_mcu_io_port_set;
  import io_port_pkg::*;
  logic              clk, arst_n, ce, ce_d, wr_stb, rd_stb, rd_d, flt, osc_strap, osc_mode;
  logic [3:0]        addr;
  logic [7:0]        wdata, rdata, rdata_d, exp_v;
  logic [19:0]       ext, ext_en; // board drive per pin, led 7:0 .. aux 19:18
  logic [19:0]       pin;         // resolved pin levels
  logic [7:0]        lo, le, lp, lh, ao, ae, ap;
  logic [1:0]        oo, oe2, op, xo, xe, xp;
  logic [7:0]        exp_q[$];    // expected read data, oldest first
  int                mismatches, checks, seed;
  mcu_io_port_set dut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .led_port_in(pin[7:0]),
    .led_port_out(lo), .led_port_oe(le), .led_port_pu(lp), .led_port_hd(lh),
    .analog_key_port_in(pin[15:8]), .analog_key_port_out(ao), .analog_key_port_oe(ae),
    .analog_key_port_pu(ap), .oscillator_shared_port_in(pin[17:16]),
    .oscillator_shared_port_out(oo), .oscillator_shared_port_oe(oe2),
    .oscillator_shared_port_pu(op), .auxiliary_port_in(pin[19:18]),
    .auxiliary_port_out(xo), .auxiliary_port_oe(xe), .auxiliary_port_pu(xp),
    .osc_strap(osc_strap), .osc_mode(osc_mode));
  pin_board #(.W(8)) b0 (.out(lo), .oe(le), .pu(lp), .ext(ext[7:0]), .ext_en(ext_en[7:0]),
    .flt(flt), .pin(pin[7:0]));
  pin_board #(.W(8)) b1 (.out(ao), .oe(ae), .pu(ap), .ext(ext[15:8]),
    .ext_en(ext_en[15:8]), .flt(flt), .pin(pin[15:8]));
  pin_board #(.W(2)) b2 (.out(oo), .oe(oe2), .pu(op), .ext(ext[17:16]),
    .ext_en(ext_en[17:16]), .flt(flt), .pin(pin[17:16]));
  pin_board #(.W(2)) b3 (.out(xo), .oe(xe), .pu(xp), .ext(ext[19:18]),
    .ext_en(ext_en[19:18]), .flt(flt), .pin(pin[19:18]));
  // clock and a wandering level for undriven pins
  initial
  begin
    clk = 1'b0;
    flt = 1'b0;
    forever
    begin
      #5 clk = ~clk;
      if (!clk) flt = ~flt;
    end
  end
  // monitor: read data only in the cycle after the strobe, zero otherwise;
  // an edge with the enable low holds whatever stood before it
  always @(posedge clk)
  begin
    rd_d    <= rd_stb & ce;
    ce_d    <= ce;
    rdata_d <= rdata;
  end
  always @(negedge clk)
  begin
    if (rd_d && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK("rdata", exp_v, rdata)
    end
    else if (arst_n && !ce_d) `CHK("rdata hold", rdata_d, rdata)
    else if (arst_n) `CHK("rdata idle", 8'h00, rdata)
  end
  // watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr_stb <= 1'b1; rd_stb <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    addr <= a; rd_stb <= 1'b1; wr_stb <= 1'b0; exp_q.push_back(e);
    @(posedge clk);
  endtask : rd
  task automatic idle(input int n);
    wr_stb <= 1'b0; rd_stb <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle
  // pin-side outputs of port p packed as out, oe, pu, hd
  function automatic logic [31:0] port_pins(input int p);
    case (p)
      0: return {lo, le, lp, lh};
      1: return {ao, ae, ap, 8'h00};
      2: return {6'h00, oo, 6'h00, oe2, 6'h00, op, 8'h00};
      default: return {6'h00, xo, 6'h00, xe, 6'h00, xp, 8'h00};
    endcase
  endfunction : port_pins
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  initial
  begin : main
    int          off[4];
    logic [7:0]  m, d, dr, pr, hd, e, ed, pub, lvl;
    logic [31:0] pp;
    logic [19:0] nx, nxe;
    off = '{0, 8, 16, 18};
    seed = 32'h0E4C;
    {arst_n, ce, wr_stb, rd_stb, osc_strap} = 5'b01000;
    addr = 4'h0; wdata = 8'h00; ext = 20'hA5C3A; ext_en = 20'hFFFFF;
    mismatches = 0; checks = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    idle(2); // pins need two enabled edges through the synchroniser
    // reset values, unmapped place and the fixed oscillator direction
    for (int p = 0; p < 4; p++)
    begin
      m = (p < 2) ? 8'hFF : 8'h03;
      e = (ext >> off[p]) & m & ((p == 2) ? 8'hFE : 8'hFF);
      rd(4'(2 * p), e);
      rd(4'(2 * p + 1), (p == 2) ? 8'h01 : 8'h00);
    end
    wr(4'h5, 8'h00);
    wr(4'hC, 8'hFF);
    for (int a = 8; a < 16; a++) rd(4'(a), 8'h00);
    idle(2);
    `CHK("osc mode", 1'b0, osc_mode)
    // random data, direction and pull-up on every port, high drive on the led port
    for (int it = 0; it < 12; it++)
    begin
      int p;
      p = it % 4;
      m = (p < 2) ? 8'hFF : 8'h03;
      d = $random(seed); dr = $random(seed); pr = $random(seed); hd = $random(seed);
      e = $random(seed);
      ed = (dr & m) | ((p == 2) ? 8'h01 : 8'h00);
      pub = ((p < 2) ? pr : (pr >> ((p == 2) ? 0 : 2))) & m & ~ed;
      nx = ext;
      nxe = ext_en;
      for (int i = 0; i < 8; i++)
        if (m[i]) {nx[off[p] + i], nxe[off[p] + i]} = {e[i], ~pub[i]};
      ext <= nx;
      ext_en <= nxe;
      wr(4'(2 * p), d);
      wr(4'(2 * p + 1), dr);
      wr((p < 2) ? 4'(8 + p) : 4'hA, (p < 2) ? pr : pr & 8'h0F);
      wr(4'hB, hd);
      idle(3);
      @(negedge clk);
      pp = port_pins(p);
      `CHK("out", d & m, pp[31:24])
      `CHK("oe", ed, pp[23:16])
      `CHK("pu", pub, pp[15:8])
      `CHK("hd", (p == 0) ? hd & ed : 8'h00, pp[7:0])
      lvl = (ed & d) | (~ed & pub) | (~ed & ~pub & e);
      @(posedge clk);
      rd(4'(2 * p), lvl & m);
      rd(4'(2 * p + 1), ed);
      rd((p < 2) ? 4'(8 + p) : 4'hA, (p < 2) ? pr : pr & 8'h0F);
      rd(4'hB, hd);
      // a write with the clock enable low must be ignored
      ce <= 1'b0;
      wr(4'(2 * p + 1), 8'hFF);
      ce <= 1'b1;
      rd(4'(2 * p + 1), ed);
      idle(2);
    end
    // reset in mid-run clears the pins at once, except the oscillator bit0 output enable
    // the strap is set across this reset, so the pins go to clock use
    arst_n <= 1'b0;
    osc_strap <= 1'b1;
    @(negedge clk);
    for (int p = 0; p < 4; p++)
      `CHK("reset pins", (p == 2) ? 32'h00010000 : 32'h0, port_pins(p))
    @(posedge clk);
    arst_n <= 1'b1;
    idle(4);
    @(negedge clk);
    `CHK("osc mode set", 1'b1, osc_mode)
    `CHK("osc pins released", 32'h0, port_pins(2))
    `CHK("queue empty", 0, exp_q.size())
    complete_run();
  end : main
endmodule : tb_mcu_io_port_set
`default_nettype wire
